/* design/emi_pkg.sv */
// Overview of operation
// - four wait-state settings per sector, setting zero adds no wait state
// - external space splits at a programmable boundary, each sector has own setting
// - software picks how many high address lines are driven, rest return to port
// - optional bus keeper on the muxed lines, switchable by software
// - low lines carry address byte first, then data byte of the same access
// - low address byte is valid on the muxed lines when the latch strobe falls
// - latch strobe stays low for the whole data phase
// - while enabled, the interface owns the direction of its assigned pins
// - each access is classed internal or external from its address and the enable bit
// - external access drives address, write data and strobes onto the pins
// - while enabled, internal accesses still move address, write data and latch pins
// - read and write strobes stay inactive through internal accesses
// - when disabled, the pins show ordinary port values and directions
// - when disabled, addresses above internal memory never alias into it
// - interface works only while the enable bit is set
// - zero-wait external byte write takes one cycle more than internal, a read three more
// - one, two, three wait states make a write take two, three, four cycles more than internal
// - enabled keeper holds the last driven value while the lines float
package emi_pkg;

  localparam logic [15:0] INT_TOP       = 16'h21FF;
  localparam int          INT_DEPTH     = 32'h0000_2200;
  localparam int          SECTOR_SHIFT  = 32'h0000_000D;
  localparam logic [2:0]  HI_NONE       = 3'h7;
  localparam logic [7:0]  HI_ALL        = 8'hFF;
  localparam logic [2:0]  SETUP_CYC     = 3'h1;
  localparam logic [2:0]  CAPT_CYC      = 3'h2;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [2:0]  RST_CTL       = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_DATA = 3'h3,
    ST_CAPT = 3'h2,
    ST_RESP = 3'h6
  } emi_state_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } emi_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic       ext;
  } emi_rsp_t;

endpackage : emi_pkg

/* design/emi_ctrl.sv */
`timescale 1ns/1ps

module emi_fifo2 #(
  parameter int W = 9
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [1:0]   count_q;
  logic [1:0]   count_d;
  logic [W-1:0] tail_q;
  wire          push = in_valid & in_ready;
  wire          pop  = out_valid & out_ready;

  assign count_d = count_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_q   <= 2'h0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
      tail_q    <= '0;
    end else if (clk_en) begin
      count_q   <= count_d;
      in_ready  <= (count_d != 2'h2);
      out_valid <= (count_d != 2'h0);
      if (pop && count_q == 2'h2) begin
        out_data <= tail_q;
      end else if (push && (count_q == 2'h0 || (pop && count_q == 2'h1))) begin
        out_data <= in_data;
      end
      if (push && (count_q == 2'h2 || (count_q == 2'h1 && !pop))) begin
        tail_q <= in_data;
      end
    end
  end
endmodule : emi_fifo2

module emi_ctrl (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire logic               ext_mem_enable_bit,
  input  wire logic [2:0]         sector_limit,
  input  wire logic [1:0]         wait_lower,
  input  wire logic [1:0]         wait_upper,
  input  wire logic [2:0]         high_addr_release,
  input  wire logic               keeper_enable,
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire emi_pkg::emi_req_t  req,
  output logic                    rsp_valid,
  input  wire logic               rsp_ready,
  output emi_pkg::emi_rsp_t       rsp,
  input  wire logic [7:0]         port_ad_val,
  input  wire logic [7:0]         port_ad_dir,
  input  wire logic [7:0]         port_hi_val,
  input  wire logic [7:0]         port_hi_dir,
  input  wire logic [2:0]         port_ctl_val,
  input  wire logic [2:0]         port_ctl_dir,
  input  wire logic [7:0]         muxed_addr_data_bus_pin,
  output logic [7:0]              muxed_addr_data_bus_drv,
  output logic [7:0]              muxed_addr_data_bus_oe,
  output logic                    keeper_hold,
  output logic [7:0]              high_addr_bus_drv,
  output logic [7:0]              high_addr_bus_oe,
  output logic                    addr_latch,
  output logic                    rd_n,
  output logic                    wr_n,
  output logic [2:0]              ctl_oe
);
  emi_pkg::emi_state_t state_q;
  emi_pkg::emi_state_t state_d;
  emi_pkg::emi_req_t   cur_q;
  emi_pkg::emi_req_t   cur_d;
  emi_pkg::emi_rsp_t   rsp_in;
  logic [2:0]          cnt_q;
  logic [2:0]          cnt_d;
  logic                ext_q;
  logic                ext_d;
  logic [1:0]          ws_q;
  logic [1:0]          ws_d;
  logic [7:0]          rdata_q;
  logic [7:0]          ad_s1_q;
  logic [7:0]          ad_s2_q;
  logic [7:0]          int_mem [0:emi_pkg::INT_DEPTH-1];
  logic                fifo_in_ready;
  logic [2:0]          data_len_q;

  // address decode uses the enable bit and the programmed sector_limit boundary
  wire        en          = ext_mem_enable_bit;
  wire        in_internal = req.addr <= emi_pkg::INT_TOP;
  wire [15:0] boundary    = {13'h0000, sector_limit} << emi_pkg::SECTOR_SHIFT;
  wire        in_upper    = req.addr >= boundary;
  wire [1:0]  in_ws       = in_upper ? wait_upper : wait_lower;
  wire        in_ext      = en & ~in_internal;
  wire        accept      = req_valid & req_ready;
  wire        cur_int     = cur_q.addr <= emi_pkg::INT_TOP;
  // zero wait: setup cycle plus one strobe cycle, i.e. one extra over internal
  wire [2:0]  ext_last    = {1'b0, ws_q} + emi_pkg::SETUP_CYC;
  wire        data_last   = ext_q ? (cnt_q == ext_last) : 1'b1;
  wire        capt_last   = cnt_q == emi_pkg::CAPT_CYC - 3'h1;

  assign cur_d = accept ? req : cur_q;
  assign ext_d = accept ? in_ext : ext_q;
  assign ws_d  = accept ? in_ws : ws_q;
  assign rsp_in = '{rdata: rdata_q, ext: ext_q};

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      emi_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = emi_pkg::ST_ADDR;
        end
        cnt_d = 3'h0;
      end
      emi_pkg::ST_ADDR: begin
        state_d = emi_pkg::ST_DATA;
        cnt_d   = 3'h0;
      end
      emi_pkg::ST_DATA: begin
        if (data_last) begin
          state_d = (ext_q && !cur_q.we) ? emi_pkg::ST_CAPT : emi_pkg::ST_RESP;
          cnt_d   = 3'h0;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      emi_pkg::ST_CAPT: begin
        if (capt_last) begin
          state_d = emi_pkg::ST_RESP;
          cnt_d   = 3'h0;
        end else begin
          cnt_d = cnt_q + 3'h1;
        end
      end
      emi_pkg::ST_RESP: begin
        // a full response buffer stalls the access engine here
        if (fifo_in_ready) begin
          state_d = emi_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = emi_pkg::ST_IDLE;
        cnt_d   = 3'h0;
      end
    endcase
  end

  // next pin values; internal accesses move address/write data/latch too
  wire       nx_addr   = en & (state_d == emi_pkg::ST_ADDR);
  wire       nx_data   = en & (state_d == emi_pkg::ST_DATA);
  wire       nx_ad_oe  = nx_addr | (nx_data & cur_d.we);
  wire [7:0] nx_ad     = nx_addr ? cur_d.addr[7:0] : cur_d.wdata;
  // strobe skips the first data cycle so write data settles first
  wire       nx_strobe = nx_data & ext_d & (cnt_d != 3'h0);
  wire       nx_rd_n   = ~(nx_strobe & ~cur_d.we);
  wire       nx_wr_n   = ~(nx_strobe & cur_d.we);
  wire [7:0] hi_mask   = (high_addr_release == emi_pkg::HI_NONE) ? 8'h00 :
                         (emi_pkg::HI_ALL >> high_addr_release);
  wire [7:0] pin_ad    = en ? (nx_ad_oe ? nx_ad : muxed_addr_data_bus_drv) : port_ad_val;
  wire [7:0] pin_ad_oe = en ? {8{nx_ad_oe}} : port_ad_dir;
  wire [7:0] pin_hi    = en ? ((cur_d.addr[15:8] & hi_mask) | (port_hi_val & ~hi_mask))
                            : port_hi_val;
  wire [7:0] pin_hi_oe = en ? (hi_mask | (port_hi_dir & ~hi_mask)) : port_hi_dir;
  wire       pin_keep  = en & keeper_enable & ~nx_ad_oe;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= emi_pkg::ST_IDLE;
      cnt_q   <= 3'h0;
      cur_q   <= '0;
      ext_q   <= 1'b0;
      ws_q    <= 2'h0;
      req_ready <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      cur_q   <= cur_d;
      ext_q   <= ext_d;
      ws_q    <= ws_d;
      req_ready <= (state_d == emi_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      muxed_addr_data_bus_drv <= emi_pkg::RST_BYTE;
      muxed_addr_data_bus_oe  <= emi_pkg::RST_BYTE;
      keeper_hold             <= 1'b0;
      high_addr_bus_drv       <= emi_pkg::RST_BYTE;
      high_addr_bus_oe        <= emi_pkg::RST_BYTE;
      addr_latch              <= 1'b0;
      rd_n                    <= 1'b1;
      wr_n                    <= 1'b1;
      ctl_oe                  <= emi_pkg::RST_CTL;
    end else if (clk_en) begin
      muxed_addr_data_bus_drv <= pin_ad;
      muxed_addr_data_bus_oe  <= pin_ad_oe;
      keeper_hold             <= pin_keep;
      high_addr_bus_drv       <= pin_hi;
      high_addr_bus_oe        <= pin_hi_oe;
      addr_latch              <= en ? nx_addr : port_ctl_val[0];
      rd_n                    <= en ? nx_rd_n : port_ctl_val[1];
      wr_n                    <= en ? nx_wr_n : port_ctl_val[2];
      ctl_oe                  <= en ? 3'h7 : port_ctl_dir;
    end
  end

  // pin input synchroniser; costs two cycles after the read strobe ends
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ad_s1_q <= 8'h00;
      ad_s2_q <= 8'h00;
    end else if (clk_en) begin
      ad_s1_q <= muxed_addr_data_bus_pin;
      ad_s2_q <= ad_s1_q;
    end
  end

  // internal memory; out-of-range addresses when disabled read zero
  always_ff @(posedge clk_sys) begin
    if (clk_en && state_q == emi_pkg::ST_DATA && !ext_q && cur_int && cur_q.we) begin
      int_mem[cur_q.addr[13:0]] <= cur_q.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      // external writes answer zero instead of a stale read byte
      if (state_q == emi_pkg::ST_DATA && (!ext_q || cur_q.we)) begin
        rdata_q <= (cur_int && !cur_q.we) ? int_mem[cur_q.addr[13:0]] : 8'h00;
      end else if (state_q == emi_pkg::ST_CAPT && capt_last) begin
        rdata_q <= ad_s2_q;
      end
    end
  end

  emi_fifo2 #(
    .W (9)
  ) u_rsp_buf (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .in_valid  (state_q == emi_pkg::ST_RESP),
    .in_ready  (fifo_in_ready),
    .in_data   (rsp_in),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp)
  );

  // helper: data-phase length of the access in progress
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_len_q <= 3'h0;
    end else if (clk_en) begin
      data_len_q <= (state_q == emi_pkg::ST_DATA) ? data_len_q + 3'h1 : 3'h0;
    end
  end

  a_data_len: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && state_q == emi_pkg::ST_DATA && state_d != emi_pkg::ST_DATA)
      |-> data_len_q == (ext_q ? {1'b0, ws_q} + 3'h1 : 3'h0))
    else $error("data phase length wrong");
  a_int_no_strobe: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!ext_q && state_q != emi_pkg::ST_IDLE && en) |-> (rd_n && wr_n))
    else $error("strobe during internal access");
  a_one_strobe: assert property (@(posedge clk_sys) disable iff (!resetn)
    en |-> !(!rd_n && !wr_n))
    else $error("both strobes active");
  a_ale_data_low: assert property (@(posedge clk_sys) disable iff (!resetn)
    (en && state_q == emi_pkg::ST_DATA) |-> !addr_latch)
    else $error("latch strobe high in data phase");
  a_addr_at_fall: assert property (@(posedge clk_sys) disable iff (!resetn)
    (en && addr_latch) |-> (muxed_addr_data_bus_drv == cur_q.addr[7:0]
                            && muxed_addr_data_bus_oe == 8'hFF))
    else $error("address not on lines at latch");
  a_wr_data_held: assert property (@(posedge clk_sys) disable iff (!resetn)
    (en && !wr_n) |-> (muxed_addr_data_bus_oe == 8'hFF
                       && muxed_addr_data_bus_drv == cur_q.wdata))
    else $error("write data not driven under strobe");
  a_rd_released: assert property (@(posedge clk_sys) disable iff (!resetn)
    (en && !rd_n) |-> (muxed_addr_data_bus_oe == 8'h00))
    else $error("lines driven during read strobe");
  a_port_revert: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && !en) |=> (muxed_addr_data_bus_oe == $past(port_ad_dir)
                         && high_addr_bus_drv == $past(port_hi_val)))
    else $error("pins not returned to port");
  a_hi_release: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && en) |=> (high_addr_bus_oe & $past(hi_mask)) == $past(hi_mask))
    else $error("selected high lines not driven");
  a_keeper_idle: assert property (@(posedge clk_sys) disable iff (!resetn)
    keeper_hold |-> muxed_addr_data_bus_oe == 8'h00)
    else $error("keeper while lines driven");
  a_ext_decide: assert property (@(posedge clk_sys) disable iff (!resetn)
    (clk_en && accept) |=> ext_q == ($past(en) && ($past(req.addr) > emi_pkg::INT_TOP)))
    else $error("internal or external decode wrong");

endmodule : emi_ctrl

/* test/emi_ext_mem.sv */
`timescale 1ns/1ps

module emi_ext_mem (
  input  wire logic       clk_sys,
  input  wire logic [7:0] ad_drv,
  input  wire logic [7:0] ad_oe,
  input  wire logic [7:0] hi_drv,
  input  wire logic       keep,
  input  wire logic       gate,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  output logic      [7:0] ad_pin
);
  logic [7:0]  mem [0:65535];
  logic [7:0]  lo_q;
  logic [7:0]  last_q;
  logic [15:0] addr;

  assign addr = {hi_drv, lo_q};
  // loads at each clock edge while the gate is high; the value held is the one seen just before it fell
  always @(posedge clk_sys) if (gate) lo_q <= ad_pin;
  // sampled at each strobe cycle's edge, so the last strobe cycle's data lands
  always @(posedge clk_sys) if (wr_n === 1'b0) mem[addr] <= ad_pin;
  // nobody drives: keeper holds, else a pattern that flips every cycle
  assign ad_pin = (ad_oe & ad_drv)
                | (~ad_oe & (!rd_n ? mem[addr] : keep ? ad_drv : ~last_q));
  always @(posedge clk_sys) last_q <= ad_pin;
endmodule : emi_ext_mem

/* test/emi_ctrl_bench.sv */
`timescale 1ns/1ps

module emi_ctrl_bench;
  logic              clk_sys = 1'b0, resetn = 1'b0, clk_en = 1'b1, ext_mem_enable_bit = 1'b0;
  logic [2:0]        sector_limit = 3'h0, high_addr_release = 3'h0;
  logic [1:0]        wait_lower = 2'h0, wait_upper = 2'h0;
  logic              keeper_enable = 1'b0, req_valid = 1'b0, rsp_ready = 1'b0;
  emi_pkg::emi_req_t req = '0;
  emi_pkg::emi_rsp_t rsp;
  logic [7:0]        port_ad_val = 8'h00, port_ad_dir = 8'h00, port_hi_val = 8'h00;
  logic [7:0]        port_hi_dir = 8'h00;
  logic [2:0]        port_ctl_val = 3'h6, port_ctl_dir = 3'h0;
  logic [7:0]        muxed_addr_data_bus_pin, muxed_addr_data_bus_drv, muxed_addr_data_bus_oe;
  logic [7:0]        high_addr_bus_drv, high_addr_bus_oe, lat_lo, pin_h;
  logic [2:0]        ctl_oe;
  logic              req_ready, rsp_valid, keeper_hold, addr_latch, rd_n, wr_n, kh_seen, lat_h;
  int                err_count = 0, check_count = 0, rd_cnt, wr_cnt, cyc = 0;

  emi_ctrl emi_ctrl_i (.clk_sys, .resetn, .clk_en, .ext_mem_enable_bit, .sector_limit,
    .wait_lower, .wait_upper, .high_addr_release, .keeper_enable, .req_valid, .req_ready,
    .req, .rsp_valid, .rsp_ready, .rsp, .port_ad_val, .port_ad_dir, .port_hi_val,
    .port_hi_dir, .port_ctl_val, .port_ctl_dir, .muxed_addr_data_bus_pin,
    .muxed_addr_data_bus_drv, .muxed_addr_data_bus_oe, .keeper_hold, .high_addr_bus_drv,
    .high_addr_bus_oe, .addr_latch, .rd_n, .wr_n, .ctl_oe);

  emi_ext_mem emi_ext_mem_i (.clk_sys, .ad_drv(muxed_addr_data_bus_drv),
    .ad_oe(muxed_addr_data_bus_oe), .hi_drv(high_addr_bus_drv), .keep(keeper_hold),
    .gate(addr_latch), .rd_n, .wr_n, .ad_pin(muxed_addr_data_bus_pin));

  always #10 clk_sys = ~clk_sys;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // pin watcher, off the sampling edge so registered outputs have settled
  always @(negedge clk_sys) begin
    if (lat_h && !addr_latch) lat_lo = pin_h;
    lat_h = addr_latch;
    pin_h = muxed_addr_data_bus_pin;
    if (rd_n === 1'b0) rd_cnt++;
    if (rd_n === 1'b0 && keeper_hold === 1'b1) kh_seen = 1'b1;
    if (wr_n === 1'b0) begin
      wr_cnt++;
      check("wr_oe", muxed_addr_data_bus_oe, 8'hFF);
      check("wr_data", muxed_addr_data_bus_drv, req.wdata);
    end
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic send(input logic we, input logic [15:0] a, input logic [7:0] d);
    req_valid <= 1'b1;
    req <= '{we: we, addr: a, wdata: d};
    @(negedge clk_sys);
    while (req_ready !== 1'b1) @(negedge clk_sys);
    @(posedge clk_sys);
    req_valid <= 1'b0;
    rd_cnt = 0;
    wr_cnt = 0;
    kh_seen = 1'b0;
  endtask : send

  task automatic recv(output logic [7:0] r, output logic e, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    check("rsp_valid", 16'(rsp_valid), 16'h0001);
    r = rsp.rdata;
    e = rsp.ext;
    @(posedge clk_sys);
    rsp_ready <= 1'b1;
    @(posedge clk_sys);
    rsp_ready <= 1'b0;
  endtask : recv

  task automatic acc(input logic we, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] r, output logic e, output int n);
    send(we, a, d);
    recv(r, e, n);
  endtask : acc

  task automatic t_disabled();
    logic [7:0] r;
    logic       e;
    int         n;
    port_ad_val <= 8'hA5;
    port_ad_dir <= 8'h3C;
    repeat (3) @(posedge clk_sys);
    check("dis_drv", muxed_addr_data_bus_drv, 8'hA5);
    check("dis_oe", muxed_addr_data_bus_oe, 8'h3C);
    check("dis_ctl", ctl_oe, 3'h0);
    acc(1'b1, 16'h1000, 8'h77, r, e, n);
    acc(1'b1, 16'h9000, 8'h3C, r, e, n);
    acc(1'b0, 16'h1000, 8'h00, r, e, n);
    check("int_keep", r, 8'h77);
    acc(1'b0, 16'h9000, 8'h00, r, e, n);
    check("dis_rdata", r, 8'h00);
    check("dis_strobe", 16'(rd_cnt + wr_cnt), 16'h0000);
  endtask : t_disabled

  task automatic t_wait();
    logic [7:0]  r, d;
    logic        e;
    logic [15:0] a, b;
    int          ni, nw, nr;
    ext_mem_enable_bit <= 1'b1;
    for (int ws = 0; ws < 4; ws++) begin
      @(posedge clk_sys);
      wait_upper <= 2'(ws);
      keeper_enable <= ws[0];
      a = 16'h04C0 + 16'(ws);
      b = a + 16'h3000;
      d = 8'h96 + 8'(ws);
      acc(1'b1, a, 8'h11, r, e, ni);
      check("int_strobe", 16'(rd_cnt + wr_cnt), 16'h0000);
      check("int_ext", e, 1'b0);
      check("int_latch", lat_lo, a[7:0]);
      acc(1'b1, b, d, r, e, nw);
      check("wr_lat", 16'(nw - ni), 16'(1 + ws));
      check("wr_cnt", 16'(wr_cnt), 16'(1 + ws));
      check("wr_latch", lat_lo, b[7:0]);
      check("wr_ext", e, 1'b1);
      acc(1'b0, b, 8'h00, r, e, nr);
      check("rd_data", r, d);
      check("rd_cnt", 16'(rd_cnt), 16'(1 + ws));
      check("rd_nowr", 16'(wr_cnt), 16'h0000);
      check("keeper", kh_seen, 16'(ws & 1));
    end
  endtask : t_wait

  task automatic t_sector();
    logic [7:0] r;
    logic       e;
    int         ni, nl, nu;
    sector_limit <= 3'h4;
    wait_lower <= 2'h2;
    wait_upper <= 2'h0;
    acc(1'b1, 16'h0100, 8'h01, r, e, ni);
    acc(1'b1, 16'h7FFF, 8'h02, r, e, nl);
    acc(1'b1, 16'h8000, 8'h03, r, e, nu);
    check("lower_lat", 16'(nl - ni), 16'h0003);
    check("upper_lat", 16'(nu - ni), 16'h0001);
  endtask : t_sector

  task automatic t_release();
    logic [7:0] m;
    port_hi_dir <= 8'hA0;
    port_hi_val <= 8'h5A;
    for (int n = 0; n < 8; n++) begin
      high_addr_release <= 3'(n);
      repeat (3) @(posedge clk_sys);
      m = (n == 7) ? 8'h00 : 8'hFF >> n;
      check("hi_oe", high_addr_bus_oe, m | (8'hA0 & ~m));
      check("hi_drv", high_addr_bus_drv, (8'h80 & m) | (8'h5A & ~m));
      check("ctl_oe", ctl_oe, 3'h7);
    end
    high_addr_release <= 3'h0;
  endtask : t_release

  // receiver stalls: two answers park in the buffer, the third holds the engine
  task automatic t_buffer();
    logic [7:0] r;
    logic       e;
    int         n;
    for (int i = 0; i < 3; i++) acc(1'b1, 16'h0010 + 16'(i), 8'hD0 + 8'(i), r, e, n);
    for (int i = 0; i < 3; i++) begin
      send(1'b0, 16'h0010 + 16'(i), 8'h00);
      @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    check("stall", req_ready, 1'b0);
    for (int i = 0; i < 3; i++) begin
      recv(r, e, n);
      check("buf_data", r, 8'hD0 + 8'(i));
    end
  endtask : t_buffer

  initial begin
    repeat (4) @(posedge clk_sys);
    check("rst_rd", rd_n, 1'b1);
    check("rst_wr", wr_n, 1'b1);
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_disabled();
    t_wait();
    t_sector();
    t_release();
    t_buffer();
    print_verdict();
  end
endmodule : emi_ctrl_bench
